// file: core/wq_portal_device.sv
// Portal decode, admission and queue configuration of the data mover.
// Assumes the engine side reports dispatches and completions as pulses.
//
// Notes on behaviour
// - four portals per queue, one page each.
// - portal address gives queue, class, table.
// - absent interrupt store portals silently discard.
// - discarded non-posted write still answers Retry.
// - dedicated queue: limited equals unlimited portal.
// - shared: 64-byte non-posted only, Success/Retry.
// - limited portal admits only below threshold.
// - unlimited portal admits while any slot free.
// - unlimited portals for privileged retry fallback.
// - shared mode takes identifier from descriptor.
// - shared mode needs identifier capability enabled.
// - identifier keys cache and tags translation requests.
// - capability word reports queues, storage, modes.
// - size before device enable, rest before queue.
// - size zero queue accepts nothing.
// - locked configuration ignores writes; device and queue enable bits and the error clear still take writes.
// - mode changes only while queue disabled.
// - no interrupt requested: table type irrelevant, but absent interrupt store portals still discard.
// - completion writes record, interrupts, or both.
// - dedicated overflow drops and records error.
// - dedicated submit is one posted 64-byte write.
`timescale 1ns/1ns
module wq_portal_device import wq_portal_pkg::*; (
   // Clock, reset and enable.
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   // Fabric side.
   wq_portal_if.device link,
   // Straps.
   input wire logic ims_supported,
   input wire logic pasid_enabled,
   input wire logic cfg_locked,
   // Engine dispatch.
   input wire logic dispatch_valid,
   input wire logic [QIDX_W-1:0] dispatch_queue,
   // Admitted descriptor.
   output logic admit_valid,
   output logic [QIDX_W-1:0] admit_queue,
   output logic [PASID_W-1:0] admit_pasid,
   output logic admit_ims,
   output logic admit_intr,
   // Engine completion.
   input wire logic done_valid,
   input wire logic done_fault,
   input wire logic done_rec_req,
   input wire logic done_intr_req,
   input wire logic done_ims,
   // Completion notification.
   output logic rec_write,
   output logic intr_issue,
   output logic intr_ims
);
   typedef struct packed {
      logic dev_en;
      logic [NUM_QUEUES-1:0][COUNT_W-1:0] q_size;
      logic [NUM_QUEUES-1:0][COUNT_W-1:0] q_thr;
      queue_mode_type [NUM_QUEUES-1:0] q_mode;
      logic [NUM_QUEUES-1:0] q_en;
      logic [NUM_QUEUES-1:0][PASID_W-1:0] q_pasid;
      logic err_ovf;
      logic [QIDX_W-1:0] err_q;
      logic [DATA_W-1:0] rdata;
      logic rsp_valid;
      logic rsp_retry;
      logic admit_valid;
      logic [QIDX_W-1:0] admit_queue;
      logic [PASID_W-1:0] admit_pasid;
      logic admit_ims;
      logic admit_intr;
      logic rec_write;
      logic intr_issue;
      logic intr_ims;
   } device_state_type;

   device_state_type state;
   device_state_type next_state;
   logic [NUM_QUEUES-1:0][COUNT_W-1:0] occupancy;
   logic [QIDX_W-1:0] sub_queue;
   logic sub_lim;
   logic sub_ims;
   logic accept;
   logic usable;
   logic form_ok;
   logic room;
   logic [COUNT_W-1:0] limit;
   logic [COUNT_W-1:0] occ;
   logic [QIDX_W-1:0] cq;
   logic [CFG_ADDR_W-1:0] cbase;

   // Portal page decode of the incoming write.
   assign sub_queue = page_queue(link.sub_addr);
   assign sub_lim = page_limited(link.sub_addr);
   assign sub_ims = page_ims(link.sub_addr);
   assign cq = link.cfg_addr[QIDX_W-1:0];
   assign cbase = {link.cfg_addr[CFG_ADDR_W-1:QIDX_W], {QIDX_W{1'b0}}};

   // One occupancy counter per queue; a disabled queue is emptied.
   for (genvar i = 0; i < NUM_QUEUES; i++) begin : g_count
      slot_counter u_count (
         .mclk(mclk),
         .nrst(nrst),
         .ce(ce),
         .clear(!state.q_en[i]),
         .inc(accept && sub_queue == QIDX_W'(i)),
         .dec(dispatch_valid && dispatch_queue == QIDX_W'(i)),
         .count(occupancy[i])
      );
   end

   // Admission decision for the write present this cycle.
   always_comb begin
      occ = occupancy[sub_queue];
      // Limited class applies only to shared queues.
      if (state.q_mode[sub_queue] == MODE_SHARED && sub_lim) begin
         limit = state.q_thr[sub_queue];
      end else begin
         limit = state.q_size[sub_queue];
      end
      usable = state.dev_en && state.q_en[sub_queue]
         && state.q_size[sub_queue] != '0
         && !(sub_ims && !ims_supported);
      if (state.q_mode[sub_queue] == MODE_SHARED) begin
         form_ok = link.sub_np && link.sub_len64 && pasid_enabled;
      end else begin
         form_ok = !link.sub_np && link.sub_len64;
      end
      room = occ < limit;
      accept = link.sub_valid && usable && form_ok && room;
   end

   // Next state: configuration access, then submission, then completion.
   always_comb begin
      next_state = state;
      next_state.rsp_valid = 1'b0;
      next_state.admit_valid = 1'b0;
      next_state.rec_write = 1'b0;
      next_state.intr_issue = 1'b0;
      // Configuration writes.
      if (link.cfg_wr) begin
         if (link.cfg_addr == REG_DEV_CTRL) begin
            next_state.dev_en = link.cfg_wdata[DEV_EN_BIT];
         end else if (link.cfg_addr == REG_SW_ERR) begin
            if (link.cfg_wdata[ERR_OVF_BIT]) begin
               next_state.err_ovf = 1'b0;
            end
         end else if (cbase == REG_QCFG_BASE) begin
            if (!cfg_locked) begin
               if (!state.dev_en) begin
                  next_state.q_size[cq] = link.cfg_wdata[QCFG_SIZE_LSB +: COUNT_W];
               end
               if (!state.q_en[cq]) begin
                  next_state.q_thr[cq] = link.cfg_wdata[QCFG_THR_LSB +: COUNT_W];
                  // Shared mode cannot be chosen without identifiers.
                  if (link.cfg_wdata[QCFG_MODE_BIT] && pasid_enabled) begin
                     next_state.q_mode[cq] = MODE_SHARED;
                  end else begin
                     next_state.q_mode[cq] = MODE_DEDICATED;
                  end
               end
            end
            next_state.q_en[cq] = link.cfg_wdata[QCFG_EN_BIT];
         end else if (cbase == REG_QPASID_BASE) begin
            if (!state.q_en[cq] && !cfg_locked) begin
               next_state.q_pasid[cq] = link.cfg_wdata[PASID_W-1:0];
            end
         end
      end
      // Configuration reads, answered in the next cycle.
      if (link.cfg_rd) begin
         next_state.rdata = '0;
         if (link.cfg_addr == REG_CAP) begin
            next_state.rdata[CAP_NQ_LSB +: QIDX_W + 1] = (QIDX_W + 1)'(NUM_QUEUES);
            next_state.rdata[CAP_STORE_LSB +: COUNT_W] = TOTAL_STORAGE;
            next_state.rdata[CAP_DED_BIT] = 1'b1;
            next_state.rdata[CAP_SHR_BIT] = pasid_enabled;
         end else if (link.cfg_addr == REG_DEV_CTRL) begin
            next_state.rdata[DEV_EN_BIT] = state.dev_en;
         end else if (link.cfg_addr == REG_SW_ERR) begin
            next_state.rdata[ERR_OVF_BIT] = state.err_ovf;
            next_state.rdata[ERR_Q_LSB +: QIDX_W] = state.err_q;
         end else if (cbase == REG_QCFG_BASE) begin
            next_state.rdata[QCFG_SIZE_LSB +: COUNT_W] = state.q_size[cq];
            next_state.rdata[QCFG_THR_LSB +: COUNT_W] = state.q_thr[cq];
            next_state.rdata[QCFG_MODE_BIT] = state.q_mode[cq] == MODE_SHARED;
            next_state.rdata[QCFG_EN_BIT] = state.q_en[cq];
         end else if (cbase == REG_QPASID_BASE) begin
            next_state.rdata[PASID_W-1:0] = state.q_pasid[cq];
         end else if (cbase == REG_QOCC_BASE) begin
            next_state.rdata[COUNT_W-1:0] = occupancy[cq];
         end
      end
      // Every non-posted write is answered, refused ones with Retry.
      if (link.sub_valid && link.sub_np) begin
         next_state.rsp_valid = 1'b1;
         next_state.rsp_retry = !accept;
      end
      // Dedicated overflow drops the write; the event beats a clear.
      if (link.sub_valid && usable && form_ok && !room
         && state.q_mode[sub_queue] == MODE_DEDICATED) begin
         next_state.err_ovf = 1'b1;
         next_state.err_q = sub_queue;
      end
      // Admitted descriptor handed to the dispatch side.
      if (accept) begin
         next_state.admit_valid = 1'b1;
         next_state.admit_queue = sub_queue;
         next_state.admit_intr = link.sub_intr;
         next_state.admit_ims = sub_ims && link.sub_intr;
         if (state.q_mode[sub_queue] == MODE_SHARED) begin
            next_state.admit_pasid = link.sub_pasid;
         end else begin
            next_state.admit_pasid = state.q_pasid[sub_queue];
         end
      end
      // Completion: faults always report through the record.
      if (done_valid) begin
         next_state.rec_write = done_fault || done_rec_req;
         next_state.intr_issue = done_intr_req;
         next_state.intr_ims = done_ims;
      end
   end

   // State register, frozen while ce is low.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // Outputs straight from the state register.
   assign link.rsp_valid = state.rsp_valid;
   assign link.rsp_retry = state.rsp_retry;
   assign link.cfg_rdata = state.rdata;
   assign admit_valid = state.admit_valid;
   assign admit_queue = state.admit_queue;
   assign admit_pasid = state.admit_pasid;
   assign admit_ims = state.admit_ims;
   assign admit_intr = state.admit_intr;
   assign rec_write = state.rec_write;
   assign intr_issue = state.intr_issue;
   assign intr_ims = state.intr_ims;
endmodule // wq_portal_device

// file: core/wq_portal_pkg.sv
// Shared constants, types and decode functions for the queue portal logic.
// Assumes one 10 MHz clock and one active-low asynchronous reset.
package wq_portal_pkg;
   localparam int NUM_QUEUES = 4;
   localparam int QIDX_W = 2;
   localparam int COUNT_W = 6;
   localparam int PASID_W = 20;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int CFG_ADDR_W = 8;
   localparam int SW_ADDR_W = 3;
   localparam int PAGE_BYTES = 4096;
   localparam int PAGE_LSB = $clog2(PAGE_BYTES);
   localparam int PORTAL_IMS_BIT = PAGE_LSB;
   localparam int PORTAL_LIMITED_BIT = PAGE_LSB + 1;
   localparam int QUEUE_LSB = PAGE_LSB + 2;
   localparam logic [COUNT_W-1:0] TOTAL_STORAGE = 6'h20;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 6'h01;
   // Device configuration word addresses.
   localparam logic [CFG_ADDR_W-1:0] REG_CAP = 8'h00;
   localparam logic [CFG_ADDR_W-1:0] REG_DEV_CTRL = 8'h01;
   localparam logic [CFG_ADDR_W-1:0] REG_SW_ERR = 8'h02;
   localparam logic [CFG_ADDR_W-1:0] REG_QCFG_BASE = 8'h10;
   localparam logic [CFG_ADDR_W-1:0] REG_QPASID_BASE = 8'h14;
   localparam logic [CFG_ADDR_W-1:0] REG_QOCC_BASE = 8'h18;
   // Field positions.
   localparam int CAP_NQ_LSB = 0;
   localparam int CAP_STORE_LSB = 8;
   localparam int CAP_DED_BIT = 16;
   localparam int CAP_SHR_BIT = 17;
   localparam int QCFG_SIZE_LSB = 0;
   localparam int QCFG_THR_LSB = 8;
   localparam int QCFG_MODE_BIT = 16;
   localparam int QCFG_EN_BIT = 17;
   localparam int ERR_OVF_BIT = 0;
   localparam int ERR_Q_LSB = 2;
   localparam int DEV_EN_BIT = 0;
   // Host software register addresses and bits.
   localparam logic [SW_ADDR_W-1:0] H_TARGET = 3'h0;
   localparam logic [SW_ADDR_W-1:0] H_PASID = 3'h1;
   localparam logic [SW_ADDR_W-1:0] H_CTRL = 3'h2;
   localparam logic [SW_ADDR_W-1:0] H_STATUS = 3'h3;
   localparam logic [SW_ADDR_W-1:0] H_CFG_ADDR = 3'h4;
   localparam logic [SW_ADDR_W-1:0] H_CFG_WDATA = 3'h5;
   localparam logic [SW_ADDR_W-1:0] H_CFG_CMD = 3'h6;
   localparam logic [SW_ADDR_W-1:0] H_CFG_RDATA = 3'h7;
   localparam int CTRL_NP_BIT = 0;
   localparam int CTRL_INTR_BIT = 1;
   localparam int CTRL_GO_BIT = 2;
   localparam int CTRL_ESC_BIT = 3;
   localparam int CMD_WR_BIT = 0;
   localparam int CMD_RD_BIT = 1;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_RETRY_BIT = 1;
   localparam int ST_DONE_BIT = 2;

   typedef enum logic [0:0] {
      MODE_DEDICATED = 1'b0,
      MODE_SHARED = 1'b1
   } queue_mode_type;

   // Queue index carried in the portal page number.
   function automatic logic [QIDX_W-1:0] page_queue(input logic [ADDR_W-1:0] addr);
      return addr[QUEUE_LSB +: QIDX_W];
   endfunction

   // High when the page is a limited portal.
   function automatic logic page_limited(input logic [ADDR_W-1:0] addr);
      return addr[PORTAL_LIMITED_BIT];
   endfunction

   // High when the page selects the device interrupt store.
   function automatic logic page_ims(input logic [ADDR_W-1:0] addr);
      return addr[PORTAL_IMS_BIT];
   endfunction
endpackage

// file: core/wq_portal_if.sv
// Link between the submitting host fabric and the queue portal device.
// Assumes both ends share mclk; the testbench joins the two modports.
`timescale 1ns/1ns
interface wq_portal_if;
   import wq_portal_pkg::*;
   logic sub_valid;
   logic [ADDR_W-1:0] sub_addr;
   logic sub_np;
   logic sub_len64;
   logic [PASID_W-1:0] sub_pasid;
   logic sub_intr;
   logic rsp_valid;
   logic rsp_retry;
   logic cfg_wr;
   logic cfg_rd;
   logic [CFG_ADDR_W-1:0] cfg_addr;
   logic [DATA_W-1:0] cfg_wdata;
   logic [DATA_W-1:0] cfg_rdata;

   modport device (
      input sub_valid, sub_addr, sub_np, sub_len64, sub_pasid, sub_intr,
      output rsp_valid, rsp_retry,
      input cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
      output cfg_rdata
   );

   modport host (
      output sub_valid, sub_addr, sub_np, sub_len64, sub_pasid, sub_intr,
      input rsp_valid, rsp_retry,
      output cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
      input cfg_rdata
   );
endinterface

// file: core/slot_counter.sv
// Occupancy counter of one queue: counts admitted and not yet dispatched slots.
// Assumes inc is only raised while room remains.
`timescale 1ns/1ns
module slot_counter import wq_portal_pkg::*; (
   // Clock, reset and enable.
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   // Count control.
   input wire logic clear,
   input wire logic inc,
   input wire logic dec,
   // Current occupancy.
   output logic [COUNT_W-1:0] count
);
   typedef struct packed {
      logic [COUNT_W-1:0] count;
   } counter_state_type;

   counter_state_type state;
   counter_state_type next_state;

   // Up on admit, down on dispatch, both together leave it unchanged.
   always_comb begin
      next_state = state;
      if (clear) begin
         next_state.count = '0;
      end else if (inc && !dec) begin
         next_state.count = state.count + COUNT_ONE;
      end else if (dec && !inc && state.count != '0) begin
         next_state.count = state.count - COUNT_ONE;
      end
   end

   // State register, frozen while ce is low.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign count = state.count;
endmodule // slot_counter

// file: core/wq_portal_host.sv
// Submitting party: software registers drive portal writes and config access.
// Assumes the device answers non-posted writes one cycle after they are sent.
`timescale 1ns/1ns
module wq_portal_host import wq_portal_pkg::*; (
   // Clock, reset and enable.
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   // Software register port.
   input wire logic [SW_ADDR_W-1:0] sw_addr,
   input wire logic [DATA_W-1:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [DATA_W-1:0] sw_rdata,
   // Device side.
   wq_portal_if.host link
);
   typedef enum logic [0:0] {
      H_IDLE = 1'b0,
      H_WAIT = 1'b1
   } host_fsm_type;

   typedef struct packed {
      host_fsm_type fsm;
      logic [ADDR_W-1:0] target;
      logic [PASID_W-1:0] pasid;
      logic np;
      logic intr;
      logic esc;
      logic last_retry;
      logic done;
      logic sub_valid;
      logic [CFG_ADDR_W-1:0] cfg_addr;
      logic [DATA_W-1:0] cfg_wdata;
      logic [DATA_W-1:0] cfg_rdata;
      logic cfg_wr;
      logic cfg_rd;
      logic cfg_capture;
      logic [DATA_W-1:0] rdata;
   } host_state_type;

   host_state_type state;
   host_state_type next_state;

   // Register access, submission sequencing and config forwarding.
   always_comb begin
      next_state = state;
      next_state.sub_valid = 1'b0;
      next_state.cfg_wr = 1'b0;
      next_state.cfg_rd = 1'b0;
      next_state.cfg_capture = state.cfg_rd;
      if (state.cfg_capture) begin
         next_state.cfg_rdata = link.cfg_rdata;
      end
      case (state.fsm)
         H_IDLE: begin
            if (sw_wr && sw_addr == H_CTRL && sw_wdata[CTRL_GO_BIT]) begin
               next_state.np = sw_wdata[CTRL_NP_BIT];
               next_state.intr = sw_wdata[CTRL_INTR_BIT];
               next_state.esc = sw_wdata[CTRL_ESC_BIT];
               next_state.sub_valid = 1'b1;
               next_state.done = !sw_wdata[CTRL_NP_BIT];
               next_state.last_retry = 1'b0;
               if (sw_wdata[CTRL_NP_BIT]) begin
                  next_state.fsm = H_WAIT;
               end
            end
         end
         H_WAIT: begin
            if (link.rsp_valid) begin
               // A refused limited submission may escalate once.
               if (link.rsp_retry && state.esc && page_limited(state.target)) begin
                  next_state.target[PORTAL_LIMITED_BIT] = 1'b0;
                  next_state.esc = 1'b0;
                  next_state.sub_valid = 1'b1;
               end else begin
                  next_state.last_retry = link.rsp_retry;
                  next_state.done = 1'b1;
                  next_state.fsm = H_IDLE;
               end
            end
         end
         default: begin
            next_state.fsm = H_IDLE;
         end
      endcase
      if (sw_wr) begin
         if (sw_addr == H_TARGET && state.fsm == H_IDLE) begin
            next_state.target = sw_wdata[ADDR_W-1:0];
         end else if (sw_addr == H_PASID && state.fsm == H_IDLE) begin
            next_state.pasid = sw_wdata[PASID_W-1:0];
         end else if (sw_addr == H_CFG_ADDR) begin
            next_state.cfg_addr = sw_wdata[CFG_ADDR_W-1:0];
         end else if (sw_addr == H_CFG_WDATA) begin
            next_state.cfg_wdata = sw_wdata;
         end else if (sw_addr == H_CFG_CMD) begin
            // Write wins if both command bits are set.
            next_state.cfg_wr = sw_wdata[CMD_WR_BIT];
            next_state.cfg_rd = sw_wdata[CMD_RD_BIT] && !sw_wdata[CMD_WR_BIT];
         end
      end
      if (sw_rd) begin
         next_state.rdata = '0;
         case (sw_addr)
            H_TARGET: next_state.rdata[ADDR_W-1:0] = state.target;
            H_PASID: next_state.rdata[PASID_W-1:0] = state.pasid;
            H_STATUS: begin
               next_state.rdata[ST_BUSY_BIT] = state.fsm == H_WAIT;
               next_state.rdata[ST_RETRY_BIT] = state.last_retry;
               next_state.rdata[ST_DONE_BIT] = state.done;
            end
            H_CFG_ADDR: next_state.rdata[CFG_ADDR_W-1:0] = state.cfg_addr;
            H_CFG_WDATA: next_state.rdata = state.cfg_wdata;
            H_CFG_RDATA: next_state.rdata = state.cfg_rdata;
            default: next_state.rdata = '0;
         endcase
      end
   end

   // State register, frozen while ce is low.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // Outputs from the state register; every write is one 64-byte unit.
   assign link.sub_valid = state.sub_valid;
   assign link.sub_addr = state.target;
   assign link.sub_np = state.np;
   assign link.sub_len64 = 1'b1;
   assign link.sub_pasid = state.pasid;
   assign link.sub_intr = state.intr;
   assign link.cfg_wr = state.cfg_wr;
   assign link.cfg_rd = state.cfg_rd;
   assign link.cfg_addr = state.cfg_addr;
   assign link.cfg_wdata = state.cfg_wdata;
   assign sw_rdata = state.rdata;
endmodule // wq_portal_host

// file: tb/wq_portal_sva.sv
// Checker for the portal link between the host end and the device end.
// Assumes it sits beside the link interface with its signals tied by name.
`timescale 1ns/1ns
module wq_portal_sva import wq_portal_pkg::*; (
   // Clock and reset.
   input wire logic mclk,
   input wire logic nrst,
   // Link signals.
   input wire logic sub_valid,
   input wire logic sub_np,
   input wire logic sub_len64,
   input wire logic rsp_valid,
   input wire logic rsp_retry,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [DATA_W-1:0] cfg_rdata
);
   // All checks run on the link clock and sleep during reset.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Answers, write form and pacing of the submission link.
   property p_np_answer; sub_valid && sub_np |=> rsp_valid; endproperty
   a_np_answer: assert property (p_np_answer)
      else $error("non-posted write got no answer");
   property p_answer_cause; rsp_valid |-> $past(sub_valid) && $past(sub_np); endproperty
   a_answer_cause: assert property (p_answer_cause)
      else $error("answer without a non-posted write");
   property p_len64; sub_valid |-> sub_len64; endproperty
   a_len64: assert property (p_len64)
      else $error("portal write is not full length");
   property p_sub_pulse; sub_valid |=> !sub_valid; endproperty
   a_sub_pulse: assert property (p_sub_pulse)
      else $error("second write before the answer");
   property p_retry_hold; !rsp_valid |-> $stable(rsp_retry); endproperty
   a_retry_hold: assert property (p_retry_hold)
      else $error("answer status moved without an answer");
   // Configuration access.
   property p_cfg_excl; !(cfg_wr && cfg_rd); endproperty
   a_cfg_excl: assert property (p_cfg_excl)
      else $error("config read and write together");
   property p_rdata_hold; !$past(cfg_rd) |-> $stable(cfg_rdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("config read data moved without a read");
   property p_cfg_rd_pulse; cfg_rd |=> !cfg_rd; endproperty
   a_cfg_rd_pulse: assert property (p_cfg_rd_pulse)
      else $error("config read strobe longer than one cycle");
   // Main scenarios seen.
   c_success: cover property (rsp_valid && !rsp_retry);
   c_retry: cover property (rsp_valid && rsp_retry);
   c_cfg_read: cover property (cfg_rd);
endmodule // wq_portal_sva

// file: tb/tb_top.sv
// Testbench joining the host end and the device end over the portal link.
// Assumes the package constants; software drives the host register port.
`timescale 1ns/1ns
module tb_top import wq_portal_pkg::*;;
   logic mclk;
   logic nrst = 1'b0;
   logic [2:0] sw_addr = 3'h0;
   logic [31:0] sw_wdata = 32'h0;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [31:0] sw_rdata;
   logic dispatch_valid = 1'b0;
   logic [1:0] dispatch_queue = 2'h0;
   logic done_valid = 1'b0;
   logic done_fault = 1'b0;
   logic done_rec_req = 1'b0;
   logic done_intr_req = 1'b0;
   logic lock = 1'b0;
   logic admit_valid, rec_write, intr_issue;
   logic [19:0] admit_pasid;
   logic [19:0] seen_pasid = 20'h0;
   logic [31:0] d;
   int num_errors = 0;
   int checks = 0;
   wq_portal_if u_wq_portal_if();
   wq_portal_host u_wq_portal_host(.mclk(mclk), .nrst(nrst), .ce(1'b1), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
      .link(u_wq_portal_if));
   wq_portal_device u_wq_portal_device(.mclk(mclk), .nrst(nrst), .ce(1'b1),
      .link(u_wq_portal_if), .ims_supported(1'b0), .pasid_enabled(1'b1), .cfg_locked(lock),
      .dispatch_valid(dispatch_valid), .dispatch_queue(dispatch_queue),
      .admit_valid(admit_valid), .admit_queue(), .admit_pasid(admit_pasid), .admit_ims(),
      .admit_intr(), .done_valid(done_valid), .done_fault(done_fault),
      .done_rec_req(done_rec_req), .done_intr_req(done_intr_req), .done_ims(1'b0),
      .rec_write(rec_write), .intr_issue(intr_issue), .intr_ims());
   wq_portal_sva u_wq_portal_sva(.mclk(mclk), .nrst(nrst),
      .sub_valid(u_wq_portal_if.sub_valid), .sub_np(u_wq_portal_if.sub_np),
      .sub_len64(u_wq_portal_if.sub_len64), .rsp_valid(u_wq_portal_if.rsp_valid),
      .rsp_retry(u_wq_portal_if.rsp_retry), .cfg_wr(u_wq_portal_if.cfg_wr),
      .cfg_rd(u_wq_portal_if.cfg_rd), .cfg_rdata(u_wq_portal_if.cfg_rdata));
   // The 10 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Keeps the identifier of the last admitted descriptor.
   always @(posedge mclk) begin
      if (admit_valid === 1'b1) seen_pasid <= admit_pasid;
   end
   // Compares and counts.
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Software port cycles and the access layers above them.
   task automatic sw_write(input logic [2:0] a, input logic [31:0] v);
      @(posedge mclk);
      sw_addr <= a;
      sw_wdata <= v;
      sw_wr <= 1'b1;
      @(posedge mclk);
      sw_wr <= 1'b0;
   endtask
   task automatic sw_read(input logic [2:0] a, output logic [31:0] v);
      @(posedge mclk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge mclk);
      sw_rd <= 1'b0;
      #1 v = sw_rdata;
   endtask
   task automatic cfg_write(input logic [7:0] a, input logic [31:0] v);
      sw_write(H_CFG_ADDR, {24'h0, a});
      sw_write(H_CFG_WDATA, v);
      sw_write(H_CFG_CMD, 32'h1);
   endtask
   task automatic cfg_check(input logic [7:0] a, input logic [31:0] e);
      sw_write(H_CFG_ADDR, {24'h0, a});
      sw_write(H_CFG_CMD, 32'h2);
      repeat (2) @(posedge mclk);
      sw_read(H_CFG_RDATA, d);
      check("config word", d, e);
   endtask
   // One portal write through the host, then the answer it reports.
   task automatic sub(input logic [15:0] a, input logic [3:0] c, input logic r);
      d = 32'h1;
      sw_write(H_TARGET, {16'h0, a});
      sw_write(H_CTRL, {28'h0, c});
      for (int i = 0; i < 20 && d[ST_BUSY_BIT]; i++) sw_read(H_STATUS, d);
      check("busy", d[ST_BUSY_BIT], 1'b0);
      if (c[CTRL_NP_BIT]) check("retry", d[ST_RETRY_BIT], r);
   endtask
   task automatic t_shared;
      sub(16'h1000, 4'h5, 1'b1);
      cfg_check(8'h18, 32'h0);
      sub(16'h2000, 4'h5, 1'b0);
      check("pasid", seen_pasid, 20'hA5A5A);
      sub(16'h2000, 4'h5, 1'b0);
      sub(16'h2000, 4'h5, 1'b1);
      sub(16'h0000, 4'h5, 1'b0);
      sub(16'h0000, 4'h5, 1'b0);
      sub(16'h0000, 4'h5, 1'b1);
      sub(16'h0000, 4'h4, 1'b0);
      cfg_check(8'h18, 32'h4);
   endtask
   task automatic t_dispatch;
      @(posedge mclk);
      dispatch_valid <= 1'b1;
      @(posedge mclk);
      dispatch_valid <= 1'b0;
      cfg_check(8'h18, 32'h3);
      sub(16'h2000, 4'hD, 1'b0);
      cfg_check(8'h18, 32'h4);
   endtask
   task automatic t_dedicated;
      sub(16'h6000, 4'h4, 1'b0);
      sub(16'h4000, 4'h4, 1'b0);
      cfg_check(8'h19, 32'h2);
      sub(16'h6000, 4'h4, 1'b0);
      cfg_check(8'h02, 32'h5);
      sub(16'h4000, 4'h5, 1'b1);
      sub(16'h8000, 4'h5, 1'b1);
      cfg_check(8'h1A, 32'h0);
      lock <= 1'b1;
      cfg_write(8'h13, 32'h00000500);
      cfg_check(8'h13, 32'h0);
   endtask
   task automatic t_done;
      @(posedge mclk);
      done_valid <= 1'b1;
      done_fault <= 1'b1;
      done_intr_req <= 1'b1;
      @(posedge mclk);
      done_valid <= 1'b0;
      #1 check("record", rec_write, 1'b1);
      check("interrupt", intr_issue, 1'b1);
   endtask
   // Main sequence: reset, configure, then the scenarios.
   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      sw_write(H_PASID, 32'h000A5A5A);
      cfg_check(REG_CAP, 32'h00032004);
      cfg_write(8'h10, 32'h00010204);
      cfg_write(8'h11, 32'h00000002);
      cfg_write(8'h12, 32'h00010000);
      cfg_write(REG_DEV_CTRL, 32'h1);
      cfg_write(8'h10, 32'h00030205);
      cfg_write(8'h11, 32'h00020002);
      cfg_write(8'h12, 32'h00030000);
      t_shared();
      t_dispatch();
      t_dedicated();
      t_done();
      stop_test();
   end
   // Cuts a hang short.
   initial begin
      #2000000;
      num_errors++;
      stop_test();
   end
endmodule // tb_top
